// >>> core/motor_parameter_select.sv
// motor and parameter group selection with protection mode word
`timescale 1ns/1ns
module motor_parameter_select
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_write,
   input wire logic i_read,
   output logic [7:0] o_rdata,
   // digital input commands (pins)
   input wire logic i_select_motor_two,
   input wire logic i_select_motor_three,
   input wire logic i_select_motor_four,
   input wire logic i_run_command,
   // changeover switch outputs
   output logic o_motor_one_selected_out,
   output logic o_motor_two_selected_out,
   output logic o_motor_three_selected_out,
   output logic o_motor_four_selected_out,
   // parameter group control
   output logic [1:0] o_active_group,
   output logic [1:0] o_switchable_group,
   output logic [1:0] o_common_group,
   output logic o_motor_functions_disabled,
   // protection and maintenance feature controls
   output logic o_carrier_lowering_enable,
   output logic o_input_phase_alarm,
   output logic o_output_phase_alarm,
   output logic o_cap_user_threshold,
   output logic o_cap_discharge_judge,
   output logic o_fan_lock_alarm,
   output logic o_brake_error_alarm,
   output logic o_enclosure_ip40
);
   // priority decode of the select inputs to a one-hot motor
   function automatic logic [3:0] decode_select(input logic m2, input logic m3, input logic m4);
      if (m2)
      begin
         decode_select = motor_select_pkg::motor_two;
      end
      else if (m3)
      begin
         decode_select = motor_select_pkg::motor_three;
      end
      else if (m4)
      begin
         decode_select = motor_select_pkg::motor_four;
      end
      else
      begin
         decode_select = motor_select_pkg::motor_one;
      end
   endfunction

   // one-hot motor to group index
   function automatic logic [1:0] group_index(input logic [3:0] sel);
      case (sel)
         motor_select_pkg::motor_one: group_index = 2'h0;
         motor_select_pkg::motor_two: group_index = 2'h1;
         motor_select_pkg::motor_three: group_index = 2'h2;
         motor_select_pkg::motor_four: group_index = 2'h3;
         default: group_index = 2'h0;
      endcase
   endfunction

   // switch mode of the group that a motor selects; group one has none
   function automatic logic mode_of(input logic [3:0] sel, input logic [2:0] modes);
      case (sel)
         motor_select_pkg::motor_two: mode_of = modes[0];
         motor_select_pkg::motor_three: mode_of = modes[1];
         motor_select_pkg::motor_four: mode_of = modes[2];
         default: mode_of = motor_select_pkg::switch_mode_motor;
      endcase
   endfunction

   typedef enum logic [1:0] {
      st_idle = 2'h1,
      st_pending = 2'h2
   } sel_state_t;

   logic [3:0] pins_sync;
   logic m2_sync;
   logic m3_sync;
   logic m4_sync;
   logic run_sync;

   logic [7:0] mode_word_reg;
   logic [7:0] mode_word_next;
   logic [2:0] switch_mode_reg;
   logic [2:0] switch_mode_next;
   logic [3:0] sel_reg;
   logic [3:0] sel_next;
   logic applied_mode_reg;
   logic applied_mode_next;
   sel_state_t state_reg;
   sel_state_t state_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   logic [3:0] requested;
   logic requested_mode;
   logic accept;

   input_sync
   #(
      .width(4),
      .reset_value(4'h0)
   )
   u_pin_sync
   (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_async({i_run_command, i_select_motor_four, i_select_motor_three,
         i_select_motor_two}),
      .o_sync(pins_sync)
   );

   assign m2_sync = pins_sync[0];
   assign m3_sync = pins_sync[1];
   assign m4_sync = pins_sync[2];
   assign run_sync = pins_sync[3];

   assign requested = decode_select(m2_sync, m3_sync, m4_sync);
   // the mode that gates a change is the requested group's own setting
   // going back to motor one follows the mode of the group being left
   always_comb
   begin
      if (requested == motor_select_pkg::motor_one)
      begin
         requested_mode = applied_mode_reg;
      end
      else
      begin
         requested_mode = mode_of(requested, switch_mode_reg);
      end
   end

   // parameter mode takes changes any time, motor mode only while stopped
   assign accept = (requested_mode == motor_select_pkg::switch_mode_param) ||
      !run_sync;

   // selection state
   always_comb
   begin
      sel_next = sel_reg;
      applied_mode_next = applied_mode_reg;
      state_next = state_reg;
      case (state_reg)
         st_idle:
         begin
            if (requested != sel_reg)
            begin
               if (accept)
               begin
                  sel_next = requested;
                  applied_mode_next = mode_of(requested, switch_mode_reg);
               end
               else
               begin
                  state_next = st_pending;
               end
            end
         end
         st_pending:
         begin
            // a pending change is applied with the latest request once accepted (stopped or parameter mode)
            if (requested == sel_reg)
            begin
               state_next = st_idle;
            end
            else if (accept)
            begin
               sel_next = requested;
               applied_mode_next = mode_of(requested, switch_mode_reg);
               state_next = st_idle;
            end
         end
         default:
         begin
            state_next = st_idle;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         sel_reg <= motor_select_pkg::motor_sel_reset;
         applied_mode_reg <= motor_select_pkg::switch_mode_motor;
         state_reg <= st_idle;
      end
      else
      begin
         sel_reg <= sel_next;
         applied_mode_reg <= applied_mode_next;
         state_reg <= state_next;
      end
   end

   // register writes and reads
   always_comb
   begin
      mode_word_next = mode_word_reg;
      switch_mode_next = switch_mode_reg;
      rdata_next = 8'h00;
      if (i_write)
      begin
         case (i_addr)
            motor_select_pkg::mode_word_offset: mode_word_next = i_wdata;
            motor_select_pkg::switch_mode_offset: switch_mode_next = i_wdata[2:0];
            default: mode_word_next = mode_word_reg;
         endcase
      end
      if (i_read)
      begin
         case (i_addr)
            motor_select_pkg::mode_word_offset: rdata_next = mode_word_reg;
            motor_select_pkg::switch_mode_offset: rdata_next = {5'h00, switch_mode_reg};
            motor_select_pkg::status_offset:
            begin
               rdata_next[motor_select_pkg::status_sel_lsb +: 4] = sel_reg;
               rdata_next[motor_select_pkg::status_pending_bit] = (state_reg == st_pending);
               rdata_next[motor_select_pkg::status_running_bit] = run_sync;
               rdata_next[motor_select_pkg::status_mode_bit] = applied_mode_reg;
            end
            motor_select_pkg::select_request_offset: rdata_next = {4'h0, requested};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         mode_word_reg <= motor_select_pkg::mode_word_reset;
         switch_mode_reg <= motor_select_pkg::switch_mode_reset;
         rdata_reg <= 8'h00;
      end
      else
      begin
         mode_word_reg <= mode_word_next;
         switch_mode_reg <= switch_mode_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_rdata = rdata_reg;

   // changeover switch outputs straight from the selection flip-flops
   assign o_motor_one_selected_out = sel_reg[0];
   assign o_motor_two_selected_out = sel_reg[1];
   assign o_motor_three_selected_out = sel_reg[2];
   assign o_motor_four_selected_out = sel_reg[3];

   // switchable parameters always follow; active ones only in motor mode; common stay at group zero
   assign o_switchable_group = group_index(sel_reg);
   assign o_active_group = (applied_mode_reg == motor_select_pkg::switch_mode_param) ?
      2'h0 : group_index(sel_reg);
   assign o_common_group = 2'h0;
   assign o_motor_functions_disabled = (sel_reg != motor_select_pkg::motor_one) &&
      (applied_mode_reg == motor_select_pkg::switch_mode_motor);

   // feature controls; fan lock bit has inverted sense
   assign o_carrier_lowering_enable =
      mode_word_reg[motor_select_pkg::bit_carrier_lowering];
   assign o_input_phase_alarm =
      mode_word_reg[motor_select_pkg::bit_input_phase_alarm];
   assign o_output_phase_alarm =
      mode_word_reg[motor_select_pkg::bit_output_phase_alarm];
   assign o_cap_user_threshold =
      mode_word_reg[motor_select_pkg::bit_cap_user_threshold];
   assign o_cap_discharge_judge =
      mode_word_reg[motor_select_pkg::bit_cap_discharge_judge];
   assign o_fan_lock_alarm = !mode_word_reg[motor_select_pkg::bit_fan_lock_continue];
   assign o_brake_error_alarm =
      mode_word_reg[motor_select_pkg::bit_brake_error_alarm];
   assign o_enclosure_ip40 = mode_word_reg[motor_select_pkg::bit_enclosure_ip40];
endmodule // motor_parameter_select

// >>> core/motor_select_pkg.sv
// constants, field layout and types shared by the motor parameter select block
package motor_select_pkg;
   // register map (word offsets on the plain register port)
   localparam logic [3:0] mode_word_offset = 4'h0;
   localparam logic [3:0] switch_mode_offset = 4'h1;
   localparam logic [3:0] status_offset = 4'h2;
   localparam logic [3:0] select_request_offset = 4'h3;

   // protection/maintenance mode word
   localparam int mode_word_width = 8;
   localparam logic [7:0] mode_word_reset = 8'h53;
   localparam int bit_carrier_lowering = 0;
   localparam int bit_input_phase_alarm = 1;
   localparam int bit_output_phase_alarm = 2;
   localparam int bit_cap_user_threshold = 3;
   localparam int bit_cap_discharge_judge = 4;
   localparam int bit_fan_lock_continue = 5;
   localparam int bit_brake_error_alarm = 6;
   localparam int bit_enclosure_ip40 = 7;

   // group switch mode register: bit 0 group two, bit 1 group three, bit 2 group four
   localparam logic [2:0] switch_mode_reset = 3'h0;
   localparam logic switch_mode_motor = 1'b0;
   localparam logic switch_mode_param = 1'b1;

   // status register fields
   localparam int status_sel_lsb = 0;
   localparam int status_pending_bit = 4;
   localparam int status_running_bit = 5;
   localparam int status_mode_bit = 6;

   // input synchroniser depth
   localparam int sync_stages = 3;

   // selection encodings (one-hot motor index)
   typedef enum logic [3:0] {
      motor_one = 4'h1,
      motor_two = 4'h2,
      motor_three = 4'h4,
      motor_four = 4'h8
   } motor_sel_t;

   localparam logic [3:0] motor_sel_reset = 4'h1;
endpackage

// >>> core/input_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pin inputs
`timescale 1ns/1ns
module input_sync
#(
   parameter int width = 1,
   parameter logic [width-1:0] reset_value = '0
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // raw and filtered levels
   input wire logic [width-1:0] i_async,
   output logic [width-1:0] o_sync
);
   logic [width-1:0] stage1_reg;
   logic [width-1:0] stage2_reg;
   logic [width-1:0] stage3_reg;
   logic [width-1:0] out_reg;
   logic [width-1:0] out_next;

   // stage1 feeds stage2 only; the filter looks at stage2 and stage3
   always_comb
   begin
      out_next = out_reg;
      for (int i = 0; i < width; i++)
      begin
         if (stage2_reg[i] == stage3_reg[i])
         begin
            out_next[i] = stage3_reg[i];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         stage1_reg <= reset_value;
         stage2_reg <= reset_value;
         stage3_reg <= reset_value;
         out_reg <= reset_value;
      end
      else
      begin
         stage1_reg <= i_async;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         out_reg <= out_next;
      end
   end

   assign o_sync = out_reg;
endmodule // input_sync

// >>> test/motor_select_sva.sv
// port assertions for the motor parameter select block
`timescale 1ns/1ns
module motor_select_sva
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_write,
   input wire logic i_read,
   input wire logic [7:0] o_rdata,
   // changeover and groups
   input wire logic o_motor_one_selected_out,
   input wire logic o_motor_two_selected_out,
   input wire logic o_motor_three_selected_out,
   input wire logic o_motor_four_selected_out,
   input wire logic [1:0] o_active_group,
   input wire logic [1:0] o_switchable_group,
   input wire logic [1:0] o_common_group,
   input wire logic o_motor_functions_disabled,
   // feature controls
   input wire logic o_carrier_lowering_enable,
   input wire logic o_input_phase_alarm,
   input wire logic o_output_phase_alarm,
   input wire logic o_cap_user_threshold,
   input wire logic o_cap_discharge_judge,
   input wire logic o_fan_lock_alarm,
   input wire logic o_brake_error_alarm,
   input wire logic o_enclosure_ip40
);
   logic [3:0] sel;
   logic [1:0] idx;
   logic [7:0] mode;
   assign sel = {o_motor_four_selected_out, o_motor_three_selected_out,
      o_motor_two_selected_out, o_motor_one_selected_out};
   assign idx = {sel[3] | sel[2], sel[3] | sel[1]};
   // fan output is the alarm sense, so it is the inverse of its mode bit
   assign mode = {o_enclosure_ip40, o_brake_error_alarm, ~o_fan_lock_alarm,
      o_cap_discharge_judge, o_cap_user_threshold, o_output_phase_alarm,
      o_input_phase_alarm, o_carrier_lowering_enable};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   a_one_hot_outs: assert property ($onehot(sel))
      else $error("selected outputs not one-hot");
   a_reset_defaults: assert property ($fell(i_reset) |->
      sel == motor_select_pkg::motor_sel_reset && mode == motor_select_pkg::mode_word_reset)
      else $error("wrong values after reset");
   a_mode_write: assert property (
      i_write && i_addr == motor_select_pkg::mode_word_offset |=> mode == $past(i_wdata))
      else $error("mode word write not reflected");
   a_mode_readback: assert property (
      i_read && i_addr == motor_select_pkg::mode_word_offset |=> o_rdata == $past(mode))
      else $error("mode word read back wrong");
   a_rdata_idle: assert property (!i_read |=> o_rdata == 8'h00)
      else $error("read data outside read answer");
   a_common_group: assert property (o_common_group == 2'h0)
      else $error("common group not zero");
   a_group_follow: assert property (o_switchable_group == idx)
      else $error("switchable group differs from motor");
   a_disable_motor: assert property (o_motor_functions_disabled |->
      !sel[0] && o_active_group == o_switchable_group)
      else $error("functions disabled with wrong group");
   a_active_group: assert property (
      !o_motor_functions_disabled |-> o_active_group == 2'h0)
      else $error("active group not zero");
endmodule // motor_select_sva

bind motor_parameter_select motor_select_sva u_sva (.i_clk, .i_reset, .i_addr, .i_wdata,
   .i_write, .i_read, .o_rdata, .o_motor_one_selected_out, .o_motor_two_selected_out,
   .o_motor_three_selected_out, .o_motor_four_selected_out, .o_active_group,
   .o_switchable_group, .o_common_group, .o_motor_functions_disabled,
   .o_carrier_lowering_enable, .o_input_phase_alarm, .o_output_phase_alarm,
   .o_cap_user_threshold, .o_cap_discharge_judge, .o_fan_lock_alarm,
   .o_brake_error_alarm, .o_enclosure_ip40);

// >>> test/select_source.sv
// external controller model driving the select pins and the run command
`timescale 1ns/1ns
module select_source
#(
   parameter int settle_cycles = 50000
)
(
   // clock
   input wire logic i_clk,
   // requests from the bench: {motor two, three, four} and run
   input wire logic [2:0] i_code,
   input wire logic i_run_req,
   // pins
   output logic o_select_motor_two,
   output logic o_select_motor_three,
   output logic o_select_motor_four,
   output logic o_run_command
);
   int quiet = 0;
   initial
   begin
      {o_select_motor_two, o_select_motor_three, o_select_motor_four} = 3'h0;
      o_run_command = 1'b0;
   end
   always @(posedge i_clk)
   begin
      {o_select_motor_two, o_select_motor_three, o_select_motor_four} <= i_code;
      quiet <= (i_code == {o_select_motor_two, o_select_motor_three, o_select_motor_four})
         ? quiet + 1 : 0;
      // run only rises once the selects have been still long enough
      o_run_command <= i_run_req && (o_run_command || quiet >= settle_cycles);
   end
endmodule // select_source

// >>> test/motor_parameter_select_tb.sv
// self-checking bench for the motor parameter select block
`timescale 1ns/1ns
module motor_parameter_select_tb;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [2:0] code = 3'h0;
   logic run_req = 1'b0;
   logic [7:0] rdata, feat, d;
   logic m2, m3, m4, run, dis;
   logic [3:0] sel;
   logic [1:0] act, swg, com;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;

   always #20 i_clk = ~i_clk;

   select_source #(.settle_cycles(20)) partner (.i_clk(i_clk), .i_code(code),
      .i_run_req(run_req), .o_select_motor_two(m2), .o_select_motor_three(m3),
      .o_select_motor_four(m4), .o_run_command(run));

   motor_parameter_select dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(addr),
      .i_wdata(wdata), .i_write(wr), .i_read(rd), .o_rdata(rdata),
      .i_select_motor_two(m2), .i_select_motor_three(m3), .i_select_motor_four(m4),
      .i_run_command(run), .o_motor_one_selected_out(sel[0]),
      .o_motor_two_selected_out(sel[1]), .o_motor_three_selected_out(sel[2]),
      .o_motor_four_selected_out(sel[3]), .o_active_group(act), .o_switchable_group(swg),
      .o_common_group(com), .o_motor_functions_disabled(dis),
      .o_carrier_lowering_enable(feat[0]), .o_input_phase_alarm(feat[1]),
      .o_output_phase_alarm(feat[2]), .o_cap_user_threshold(feat[3]),
      .o_cap_discharge_judge(feat[4]), .o_fan_lock_alarm(feat[5]),
      .o_brake_error_alarm(feat[6]), .o_enclosure_ip40(feat[7]));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
      // let an edge pass so a following write never reassigns the strobe in this step
      @(posedge i_clk);
   endtask

   task automatic reg_read(input logic [3:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge i_clk);
   endtask

   task automatic pins(input logic [2:0] c, input logic r);
      code <= c;
      run_req <= r;
      repeat (40) @(posedge i_clk);
   endtask

   function automatic logic [3:0] want(input logic [2:0] c);
      want = c[2] ? 4'h2 : c[1] ? 4'h4 : c[0] ? 4'h8 : 4'h1;
   endfunction

   function automatic logic [1:0] gidx(input logic [3:0] s);
      gidx = {s[3] | s[2], s[3] | s[1]};
   endfunction

   task automatic t_reset();
      check("selected", {4'h0, sel}, 8'h01);
      check("features", feat, motor_select_pkg::mode_word_reset ^ 8'h20);
      reg_read(motor_select_pkg::mode_word_offset);
      check("mode word", d, 8'h53);
      reg_read(motor_select_pkg::switch_mode_offset);
      check("switch modes", d, 8'h00);
      reg_read(4'hf);
      check("unmapped", d, 8'h00);
   endtask

   task automatic t_bits();
      for (int i = 0; i < 8; i++)
      begin
         reg_write(motor_select_pkg::mode_word_offset, 8'h01 << i);
         @(posedge i_clk);
         check("mode bit", feat, (8'h01 << i) ^ 8'h20);
      end
      reg_write(motor_select_pkg::status_offset, 8'hff);
      reg_read(motor_select_pkg::status_offset);
      check("status kept", d, 8'h01);
      reg_write(motor_select_pkg::mode_word_offset, 8'h53);
   endtask

   task automatic t_decode();
      logic [3:0] w;
      logic [7:0] e;
      for (int c = 0; c < 8; c++)
      begin
         pins(c[2:0], 1'b0);
         w = want(c[2:0]);
         e = {1'b0, ~w[0], 2'h0, gidx(w), gidx(w)};
         check("decode", {4'h0, sel}, {4'h0, w});
         check("groups", {1'b0, dis, com, act, swg}, e);
      end
      pins(3'h0, 1'b0);
   endtask

   task automatic t_hold();
      reg_write(motor_select_pkg::switch_mode_offset, 8'h01);
      pins(3'h0, 1'b1);
      pins(3'h2, 1'b1);
      check("held", {4'h0, sel}, 8'h01);
      reg_read(motor_select_pkg::status_offset);
      check("status", {2'h0, d[5:0]}, 8'h31);
      reg_read(motor_select_pkg::select_request_offset);
      check("request", d, 8'h04);
      pins(3'h4, 1'b1);
      check("param run", {4'h0, sel}, 8'h02);
      check("param grp", {dis, act}, 3'h0);
      pins(3'h2, 1'b1);
      check("held again", {4'h0, sel}, 8'h02);
      pins(3'h2, 1'b0);
      check("applied", {4'h0, sel}, 8'h04);
      pins(3'h0, 1'b0);
   endtask

   task automatic t_param();
      reg_write(motor_select_pkg::switch_mode_offset, 8'h07);
      pins(3'h0, 1'b1);
      for (int c = 1; c < 8; c = c * 2)
      begin
         pins(c[2:0], 1'b1);
         check("run change", {4'h0, sel}, {4'h0, want(c[2:0])});
         check("run groups", {2'h0, dis, com, act}, 8'h00);
         reg_read(motor_select_pkg::status_offset);
         check("run status", d, {4'h6, want(c[2:0])});
      end
      pins(3'h0, 1'b0);
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         failures++;
         summarize();
      end
   end

   initial
   begin
      repeat (10) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      t_reset();
      t_bits();
      t_decode();
      t_hold();
      t_param();
      summarize();
   end
endmodule // motor_parameter_select_tb
